// File: bench/trunk_packet_queue_scheduler_assertions.sv
// Purpose: port checks for the trunk queue scheduler
// Assumes: credit_out lags one cycle, answer two after tx_opp
// Notes:   bound to the top module
module trunk_packet_queue_scheduler_assertions #(
    parameter bit BURSTY_EN = 1'b1,
    parameter int DEPTH     = tq_pkg::DEPTH
) (
    input wire logic        mclk,       // clock
    input wire logic        rst,        // sync reset
    input wire logic        frame_tick, // slot pulse
    input wire logic        tx_opp,     // transmit chance
    input wire logic        tx_valid,   // word sent
    input wire logic        tx_idle,    // idle sent
    input wire logic [31:0] tx_data,    // sent word
    input wire logic [2:0]  tx_type,    // sent type
    input wire logic [5:0]  credit_out  // credits held
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_answer; tx_opp |-> ##2 tx_valid; endproperty
    a_answer: assert property (p_answer)
        else $error("no word after opportunity");
    property p_cause; tx_valid |-> $past(tx_opp, 2); endproperty
    a_cause: assert property (p_cause)
        else $error("word without opportunity");
    property p_idle; tx_idle |-> tx_valid && tx_data == 32'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle word malformed");
    property p_hp; credit_out[0] == 1'b0; endproperty
    a_hp: assert property (p_hp)
        else $error("credit on high priority");
    property p_bursty; tx_valid |-> BURSTY_EN || tx_type < 3'h4;
    endproperty
    a_bursty: assert property (p_bursty)
        else $error("bursty type sent while absent");
    // credits only appear two edges after a slot tick
    property p_rise; (credit_out & ~$past(credit_out)) != 6'h0
        |-> $past(frame_tick, 2); endproperty
    a_rise: assert property (p_rise)
        else $error("credit without slot");
    property p_fall; (~credit_out & $past(credit_out)) != 6'h0
        && !$past(rst) |-> $past(tx_opp) || $past(tx_opp, 2)
        || $past(tx_opp, 3) || $past(tx_opp, 4); endproperty
    a_fall: assert property (p_fall)
        else $error("credit lost without send");
    property p_clean; $fell(rst) |-> credit_out == 6'h0 && !tx_valid;
    endproperty
    a_clean: assert property (p_clean)
        else $error("outputs busy after reset");
endmodule

bind trunk_packet_queue_scheduler trunk_packet_queue_scheduler_assertions
    #(.BURSTY_EN(BURSTY_EN), .DEPTH(DEPTH)) chk_i (.mclk, .rst,
    .frame_tick, .tx_opp, .tx_valid, .tx_idle, .tx_data, .tx_type,
    .credit_out);

// File: bench/trunk_packet_queue_scheduler_tb_top.sv
// Purpose: self-checking bench with a queue model
// Assumes: one word per packet, inputs change on falling edge
// Notes:   round robin pointer assumed to start at voice
module trunk_packet_queue_scheduler_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst = 1, bus_valid = 0, rt_we = 0, rt_match = 0;
    logic tx_opp = 0, run = 0, frame_tick, tx_valid, tx_idle, drop;
    logic [7:0]  bus_addr = 8'h00, rt_addr = 8'h00;
    logic [2:0]  bus_type = 3'h0, tx_type;
    logic [31:0] bus_data = 32'h0, tx_data, s = 32'h5246F465;
    logic [95:0] rate_cfg = {6{16'hFFFF}};
    logic [17:0] bw_order = {3'h3, 3'h1, 3'h2, 3'h4, 3'h5, 3'h0};
    logic [5:0]  credit_out, mc = 6'h00;
    logic [31:0] mq[6][$];
    bit          rtm[256];
    int n_fail = 0, checks_done = 0, rr = 0, cnt[6] = '{default:0};

    trunk_packet_queue_scheduler #(.BURSTY_EN(1'b1)) dut (.mclk, .rst,
        .bus_valid, .bus_addr, .bus_type, .bus_data, .rt_we, .rt_addr,
        .rt_match, .frame_tick, .rate_cfg, .bw_order, .tx_opp,
        .tx_valid, .tx_data, .tx_type, .tx_idle, .credit_out, .drop);
    trunk_slot_gen far (.mclk, .run, .frame_tick);

    initial forever #5 mclk = ~mclk;

    // ==========================================================
    // model: credits per slot, at most one held
    always @(posedge mclk)
        if (rst)
            mc = 6'h00;
        else if (frame_tick)
            for (int i = 1; i < 6; i++)
                if (cnt[i] + 1 >= rate_cfg[16*i+:16])
                begin
                    mc[i] = 1'b1;
                    cnt[i] = 0;
                end
                else
                    cnt[i]++;

    function automatic int pick();
        int i;
        if (mq[0].size() > 0) return 0;
        for (int k = 5; k >= 0; k--)
        begin
            i = int'(bw_order[3*k+:3]);
            if (i > 0 && i < 6 && mq[i].size() > 0 && mc[i])
            begin
                mc[i] = 1'b0;
                return i;
            end
        end
        if (mq[1].size() > 0) return 1;
        if (mq[2].size() > 0) return 2;
        for (int k = 0; k < 3; k++)
        begin
            i = 3 + (rr + k) % 3;
            if (mq[i].size() > 0)
            begin
                rr = (i - 2) % 3;
                return i;
            end
        end
        return -1;
    endfunction

    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // ==========================================================
    // drivers and compare
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one idle cycle after each request keeps strobes single-edged
    task automatic rtw(input logic [7:0] a, input logic m);
        rt_we = 1'b1;
        rt_addr = a;
        rt_match = m;
        rtm[a] = m;
        @(negedge mclk);
        rt_we = 1'b0;
        @(negedge mclk);
    endtask

    task automatic put(input logic [7:0] a, input int t);
        logic [31:0] d;
        logic        f;
        d = rnd();
        f = rtm[a] && mq[t].size() >= tq_pkg::DEPTH;
        bus_valid = 1'b1;
        bus_addr = a;
        bus_type = t[2:0];
        bus_data = d;
        if (rtm[a] && !f) mq[t].push_back(d);
        @(negedge mclk);
        chk(drop, f);
        bus_valid = 1'b0;
        @(negedge mclk);
    endtask

    task automatic opp();
        int t;
        logic [31:0] d;
        t = pick();
        d = (t < 0) ? 32'h0 : mq[t].pop_front();
        tx_opp = 1'b1;
        @(negedge mclk);
        tx_opp = 1'b0;
        @(negedge mclk);
        chk({tx_valid, tx_idle}, {1'b1, t < 0});
        if (t >= 0) chk(tx_type, t);
        chk(tx_data, d);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (2000) @(posedge mclk);
        n_fail++;
        end_sim();
    end

    initial
    begin
        repeat (6) @(negedge mclk);
        chk({tx_valid, credit_out}, 32'h0);
        rst = 1'b0;
        rtw(8'h11, 1'b1);
        rtw(8'h22, 1'b0);
        put(8'h22, 1);
        put(8'h11, 2);
        put(8'h11, 0);
        repeat (3) opp();
        $display("test 1 done");
        for (int t = 3; t > 0; t--) put(8'h11, t);
        repeat (3) opp();
        for (int t = 4; t < 6; t++)
        begin
            put(8'h11, t);
            opp();
        end
        $display("test 2 done");
        rate_cfg[48+:16] = 16'h0001;
        rate_cfg[32+:16] = 16'h0002;
        run = 1'b1;
        repeat (20) @(negedge mclk);
        run = 1'b0;
        repeat (3) @(negedge mclk);
        chk(credit_out, mc);
        for (int t = 0; t < 4; t++) put(8'h11, t);
        repeat (5) opp();
        chk(credit_out, mc);
        $display("test 3 done");
        // one word past the ring depth must be refused
        repeat (17) put(8'h11, 1);
        repeat (17) opp();
        $display("test 4 done");
        end_sim();
    end
endmodule

// File: bench/trunk_slot_gen.sv
// Purpose: trunk side model, frame slot pulses
// Assumes: driven off the falling edge of mclk
// Notes:   one slot every 4 cycles while run is high
module trunk_slot_gen (
    input  wire logic mclk,      // clock
    input  wire logic run,       // slots flowing
    output logic      frame_tick // one slot pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    initial frame_tick = 1'b0;
    // ==========================================================
    // slot pacing; stops dead between bursts
    always @(negedge mclk)
    begin
        n = run ? n + 1 : 0;
        frame_tick <= run && (n % 4 == 1);
    end
endmodule

// File: src/tq_mem.sv
// Purpose: per-queue packet storage, one ring per packet type
// Assumes: one write and one read per cycle, registered read data
// Notes:   pointers are kept by the scheduler, not here
module tq_mem #(
    parameter int WIDTH = 32,
    parameter int AW    = 7
) (
    input  wire logic             mclk,   // clock
    input  wire logic             we,     // write strobe
    input  wire logic [AW-1:0]    waddr,  // write address
    input  wire logic [WIDTH-1:0] wdata,  // write data
    input  wire logic [AW-1:0]    raddr,  // read address
    output logic      [WIDTH-1:0] rdata   // registered read data
);

    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// File: src/tq_pkg.sv
// Purpose: shared constants for the trunk packet queue scheduler
// Assumes: one clock (mclk), synchronous active-high reset
// Notes:   queue indices are fixed; bandwidth order is programmed
package tq_pkg;

    // =========================================================
    // packet types / queue indices
    localparam int NUM_TYPES = 6;
    localparam int TYPE_W    = 3;
    localparam logic [2:0] Q_HIPRI = 3'h0;
    localparam logic [2:0] Q_NTS   = 3'h1;
    localparam logic [2:0] Q_TS    = 3'h2;
    localparam logic [2:0] Q_VOICE = 3'h3;
    localparam logic [2:0] Q_BDA   = 3'h4;
    localparam logic [2:0] Q_BDB   = 3'h5;

    // =========================================================
    // packet and routing sizes
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int DEPTH      = 16;
    localparam int RATE_W     = 16;
    localparam int IDLE_BYTES = 4;
    localparam logic [31:0] IDLE_WORD = 32'h0000_0000;

endpackage

// File: src/trunk_packet_queue_scheduler.sv
// Purpose: trunk card queuing and transmit scheduling
// Assumes: inputs synchronous to mclk; one word per packet
// Notes:   credit rates and bandwidth order come from config ports
//
// Contract
// R1: capture bus packet only on routing-table match
// R2: six transmit queues, one per packet type
// R3: bursty queues removable by parameter
// R4: high priority ignores credits entirely
// R5: issue credits per type at load rate
// R6: never more than one credit held
// R7: high priority queue served first
// R8: credited queues scanned in bandwidth order
// R9: fallback nts, ts, then round-robin rest
// R10: empty queues send 4-byte idle packet
// R11: credit cleared on use; pointer advances
// R12: per-type rate counter ticks per frame slot
module trunk_packet_queue_scheduler #(
    parameter bit BURSTY_EN = 1'b1,
    parameter int DEPTH     = tq_pkg::DEPTH
) (
    input  wire logic                      mclk,      // clock, 100 MHz
    input  wire logic                      rst,       // sync reset, high
    input  wire logic                      bus_valid, // bus packet present
    input  wire logic [tq_pkg::ADDR_W-1:0] bus_addr,  // bus packet address
    input  wire logic [2:0]                bus_type,  // bus packet type
    input  wire logic [tq_pkg::DATA_W-1:0] bus_data,  // bus packet word
    input  wire logic                      rt_we,     // routing table write
    input  wire logic [tq_pkg::ADDR_W-1:0] rt_addr,   // routing entry addr
    input  wire logic                      rt_match,  // entry: take packet
    input  wire logic                      frame_tick,// one frame slot
    input  wire logic [6*tq_pkg::RATE_W-1:0] rate_cfg,// slots per credit
    input  wire logic [17:0]               bw_order,  // 6x3 queue order
    input  wire logic                      tx_opp,    // transmit chance
    output logic                           tx_valid,  // word sent
    output logic [tq_pkg::DATA_W-1:0]      tx_data,   // sent word
    output logic [2:0]                     tx_type,   // sent type
    output logic                           tx_idle,   // idle packet sent
    output logic [5:0]                     credit_out,// credits held
    output logic                           drop       // queue full drop
);

    localparam int AW = $clog2(DEPTH);
    localparam int MW = AW + 3;

    // =========================================================
    // routing table
    logic route_q [0:(1<<tq_pkg::ADDR_W)-1];
    logic route_hit;

    always_ff @(posedge mclk)
    begin
        if (rt_we)
        begin
            route_q[rt_addr] <= rt_match;
        end
    end

    function automatic logic type_ok(input logic [2:0] t);
        type_ok = (t <= tq_pkg::Q_VOICE) ||
                  (BURSTY_EN && (t <= tq_pkg::Q_BDB)); // R3
    endfunction

    assign route_hit = bus_valid && route_q[bus_addr]
                       && type_ok(bus_type); // R1

    // =========================================================
    // queue pointers (six rings in one memory)
    logic [AW:0] wp_q [0:5];
    logic [AW:0] rp_q [0:5];
    logic [AW:0] wp_d [0:5];
    logic [AW:0] rp_d [0:5];
    logic [5:0]  nonempty;
    logic [5:0]  full;

    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            nonempty[i] = (wp_q[i] != rp_q[i]); // R2
            full[i]     = (wp_q[i][AW] != rp_q[i][AW]) &&
                          (wp_q[i][AW-1:0] == rp_q[i][AW-1:0]);
        end
    end

    // =========================================================
    // credits
    logic [tq_pkg::RATE_W-1:0] cnt_q [0:5];
    logic [tq_pkg::RATE_W-1:0] cnt_d [0:5];
    logic [5:0] cred_q;
    logic [5:0] cred_d;

    // =========================================================
    // selection
    logic       sel_v;
    logic [2:0] sel_q_idx;
    logic       sel_cred;
    logic [1:0] rr_q;
    logic [1:0] rr_d;

    function automatic logic [2:0] rr_queue(input logic [1:0] p);
        unique case (p)
            2'h0:    rr_queue = tq_pkg::Q_VOICE;
            2'h1:    rr_queue = tq_pkg::Q_BDA;
            default: rr_queue = tq_pkg::Q_BDB;
        endcase
    endfunction

    function automatic logic [1:0] rr_next(input logic [1:0] p);
        if (!BURSTY_EN || p == 2'h2)
        begin
            rr_next = 2'h0;
        end
        else
        begin
            rr_next = p + 2'h1;
        end
    endfunction

    always_comb
    begin
        logic [2:0] q;
        logic [1:0] p;
        q         = 3'h0;
        p         = rr_q;
        sel_v     = 1'b0;
        sel_q_idx = tq_pkg::Q_HIPRI;
        sel_cred  = 1'b0;
        rr_d      = rr_q;
        if (nonempty[tq_pkg::Q_HIPRI])
        begin
            sel_v = 1'b1; // R7 R4
        end
        else
        begin
            for (int k = 5; k >= 0; k--)
            begin
                q = bw_order[3*k +: 3];
                if (!sel_v && q != tq_pkg::Q_HIPRI && q < 3'h6 &&
                    nonempty[q] && cred_q[q])
                begin
                    sel_v     = 1'b1; // R8
                    sel_q_idx = q;
                    sel_cred  = 1'b1;
                end
            end
            if (!sel_v)
            begin
                if (nonempty[tq_pkg::Q_NTS])
                begin
                    sel_v     = 1'b1; // R9
                    sel_q_idx = tq_pkg::Q_NTS;
                end
                else if (nonempty[tq_pkg::Q_TS])
                begin
                    sel_v     = 1'b1; // R9
                    sel_q_idx = tq_pkg::Q_TS;
                end
                else
                begin
                    for (int j = 0; j < 3; j++)
                    begin
                        if (!sel_v && nonempty[rr_queue(p)])
                        begin
                            sel_v     = 1'b1; // R9
                            sel_q_idx = rr_queue(p);
                            rr_d      = rr_next(p); // R11
                        end
                        p = rr_next(p);
                    end
                end
            end
        end
        if (!tx_opp)
        begin
            sel_v    = 1'b0;
            sel_cred = 1'b0;
            rr_d     = rr_q;
        end
    end

    // =========================================================
    // pointer and credit next state
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            wp_d[i]  = wp_q[i];
            rp_d[i]  = rp_q[i];
            cnt_d[i] = cnt_q[i];
            cred_d[i] = cred_q[i];
            if (route_hit && bus_type == i[2:0] && !full[i])
            begin
                wp_d[i] = wp_q[i] + 1'b1;
            end
            if (sel_v && sel_q_idx == i[2:0])
            begin
                rp_d[i] = rp_q[i] + 1'b1;
            end
            if (sel_cred && sel_q_idx == i[2:0])
            begin
                cred_d[i] = 1'b0; // R11
            end
            if (i != 0 && frame_tick && type_ok(i[2:0]))
            begin
                if (cnt_q[i] + 1'b1 >=
                    rate_cfg[i*tq_pkg::RATE_W +: tq_pkg::RATE_W])
                begin
                    cnt_d[i] = '0; // R12
                    if (!cred_q[i] ||
                        (sel_cred && sel_q_idx == i[2:0]))
                    begin
                        cred_d[i] = 1'b1; // R5 R6
                    end
                end
                else
                begin
                    cnt_d[i] = cnt_q[i] + 1'b1; // R12
                end
            end
        end
        cred_d[0] = 1'b0; // R4
    end

    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (rst)
            begin
                wp_q[i]  <= '0;
                rp_q[i]  <= '0;
                cnt_q[i] <= '0;
            end
            else
            begin
                wp_q[i]  <= wp_d[i];
                rp_q[i]  <= rp_d[i];
                cnt_q[i] <= cnt_d[i];
            end
        end
        if (rst)
        begin
            cred_q <= 6'h00;
            rr_q   <= 2'h0;
        end
        else
        begin
            cred_q <= cred_d;
            rr_q   <= rr_d;
        end
    end

    // =========================================================
    // storage: data leaves the memory a cycle after selection
    logic [MW-1:0]               mem_wa;
    logic [MW-1:0]               mem_ra;
    logic [tq_pkg::DATA_W-1:0]   mem_rd;
    logic                        pend_v_q;
    logic                        pend_i_q;
    logic [2:0]                  pend_t_q;

    assign mem_wa = {bus_type, wp_q[bus_type][AW-1:0]};
    assign mem_ra = {sel_q_idx, rp_q[sel_q_idx][AW-1:0]};

    tq_mem #(
        .WIDTH (tq_pkg::DATA_W),
        .AW    (MW)
    ) u_mem (
        .mclk  (mclk),
        .we    (route_hit && !full[bus_type]),
        .waddr (mem_wa),
        .wdata (bus_data),
        .raddr (mem_ra),
        .rdata (mem_rd)
    );

    // =========================================================
    // transmit outputs
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pend_v_q <= 1'b0;
            pend_i_q <= 1'b0;
            pend_t_q <= 3'h0;
            drop     <= 1'b0;
        end
        else
        begin
            pend_v_q <= sel_v;
            pend_i_q <= tx_opp && !sel_v; // R10
            pend_t_q <= sel_q_idx;
            drop     <= route_hit && full[bus_type];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tx_valid   <= 1'b0;
            tx_idle    <= 1'b0;
            tx_data    <= '0;
            tx_type    <= 3'h0;
            credit_out <= 6'h00;
        end
        else
        begin
            tx_valid   <= pend_v_q || pend_i_q;
            tx_idle    <= pend_i_q; // R10
            tx_data    <= pend_i_q ? tq_pkg::IDLE_WORD : mem_rd;
            tx_type    <= pend_t_q;
            credit_out <= cred_q;
        end
    end

endmodule
